// [logic/tsc_cfg.svh]
// Constants of the timing signal controller: offsets, fields, timing counts.
// Assumes a 40 MHz pclk and a 32-bit APB master.
//Contract
//- Scan-start edge begins a scan and starts internal conversion-spacing counter.
//- Internal counter converts from scan start, reloads, reloads again at scan end.
//- Conversions outside an active acquisition sequence are suppressed.
//- Scans gated by scan-gate input or software gate bit.
//- Scan gate: any pin, level or edge, selectable polarity, never driven.
//- Level mode: active gate level blocks scan starts.
//- Edge mode: active gate edges alternately disable and enable scan starts.
//- Gate changes act only at next scan start, never mid-scan.
//- Scan-interval clock from pin, level mode, polarity, at most 20 MHz.
//- Otherwise scan-interval counter runs from 20 MHz or 100 kHz timebase.
//- Waveform trigger edge starts generation and internal update-interval counter.
//- Used waveform trigger driven out as active-high 50-100 ns pulse.
//- Update edge refreshes converters; external updates need posted-update mode.
//- Applied update driven out as active-low 300-350 ns pulse.
//- Internal update counter starts on trigger, stops by software or buffer expiry.
//- Software gate suppresses every output update.
//- Update counter clock from level pin or internal timebase, never driven.
//- Counter 0 counts selected clock edge, mirrors used clock out.
//- Counter 0 gate edge starts/stops or latches, mirrored out.
//- Counter 0 output pulses or toggles on terminal count, selectable polarity.
//- Direction from pin when enabled, else from software bit.
//- Shared-pin timing outputs come up high impedance until enabled.
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH

`define TSC_AW 8
`define TSC_CTRL 8'h00
`define TSC_SEL0 8'h04
`define TSC_SEL1 8'h08
`define TSC_OE 8'h0c
`define TSC_SI_LOAD 8'h10
`define TSC_CI_LOAD 8'h14
`define TSC_UI_LOAD 8'h18
`define TSC_NCONV 8'h1c
`define TSC_C0_LOAD 8'h20
`define TSC_STATUS 8'h24
`define TSC_C0_COUNT 8'h28
`define TSC_C0_LATCH 8'h2c

`define TSC_B_SEQ 0
`define TSC_B_AI_SWGATE 1
`define TSC_B_AO_SWGATE 2
`define TSC_B_POSTED 3
`define TSC_B_CONV_EXT 4
`define TSC_B_UPD_EXT 5
`define TSC_B_UI_STOP 6
`define TSC_B_DIR_PIN 7
`define TSC_B_DIR_SW 8
`define TSC_B_C0_TOGGLE 9
`define TSC_B_C0_POL 10
`define TSC_B_GATE_EDGE 11
`define TSC_B_SCAN_EXT 12
`define TSC_B_SI_EXT 13
`define TSC_B_SI_SLOW 14
`define TSC_B_UI_EXT 15
`define TSC_B_UI_SLOW 16
`define TSC_B_C0_EXT 17
`define TSC_B_C0_SLOW 18
`define TSC_B_C0_EN 19
`define TSC_B_C0_GATECTL 20
`define TSC_POL_LSB 8

`define TSC_PIN_UPD 5
`define TSC_PIN_WF 6
`define TSC_PIN_C0CLK 8
`define TSC_PIN_C0GATE 9

`define TSC_CLK_HZ 40000000
`define TSC_TB_FAST_HZ 20000000
`define TSC_TB_SLOW_HZ 100000
`define TSC_TB_FAST_CYC (`TSC_CLK_HZ / `TSC_TB_FAST_HZ)
`define TSC_TB_SLOW_CYC (`TSC_CLK_HZ / `TSC_TB_SLOW_HZ)
`define TSC_CLK_PS 25000
`define TSC_WF_MIN_NS 50
`define TSC_WF_CYC ((`TSC_WF_MIN_NS * 1000 + `TSC_CLK_PS - 1) / `TSC_CLK_PS)
`define TSC_UPD_MIN_NS 300
`define TSC_UPD_CYC ((`TSC_UPD_MIN_NS * 1000 + `TSC_CLK_PS - 1) / `TSC_CLK_PS)

`endif

// [logic/tsc_pkg.sv]
// Types of the timing signal controller.
// Assumes tsc_cfg.svh holds the numeric constants.
package tsc_pkg;
  typedef enum logic [1:0] {
    TSC_IDLE = 2'b01,
    TSC_SCAN = 2'b10
  } tsc_scan_t;

  typedef enum int {
    TSC_IN_SCAN = 0,
    TSC_IN_CONV = 1,
    TSC_IN_GATE = 2,
    TSC_IN_SICLK = 3,
    TSC_IN_WF = 4,
    TSC_IN_UPD = 5,
    TSC_IN_UICLK = 6,
    TSC_IN_C0CLK = 7,
    TSC_IN_C0GATE = 8
  } tsc_in_t;
endpackage : tsc_pkg

// [logic/tsc_pin_cond.sv]
// Routes one function pin into the pclk domain with polarity and edge detection.
// Assumes pins are asynchronous to pclk.
`timescale 1ns/10ps
module tsc_pin_cond import tsc_pkg::*; #(
  parameter int NPIN = 10
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and routing
  input wire logic [NPIN-1:0] pins,
  input wire logic [3:0] sel,
  input wire logic pol,
  // Conditioned signal
  output logic lvl,
  output logic act_edge
);
  logic meta;
  logic sync;
  logic lvl_d;
  wire picked = (sel < 4'(NPIN)) ? pins[sel] : 1'b0;

  // Pins are synchronized before anything decodes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      lvl_d <= 1'b0;
    end else begin
      meta <= picked;
      sync <= meta;
      lvl_d <= lvl;
    end
  end

  assign lvl = sync ^ pol;
  assign act_edge = lvl & ~lvl_d;
endmodule : tsc_pin_cond

// [logic/tsc_top.sv]
// Timing signal controller: scan and conversion gating, update timing, counter 0.
// Assumes an APB master on pclk and function pins with an external pad resolver.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "tsc_cfg.svh"
module tsc_top import tsc_pkg::*; #(
  parameter int NPIN = 10,
  parameter int CW = 24
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TSC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Function pins
  input wire logic [NPIN-1:0] programmable_function_pin_in,
  output logic [NPIN-1:0] programmable_function_pin_out,
  output logic [NPIN-1:0] programmable_function_pin_oe,
  // Counter 0 pins
  input wire logic digital_line_six,
  output logic counter0_output,
  output logic counter0_output_oe,
  // Converter side
  input wire logic buffer_expired,
  output logic adc_convert,
  output logic dac_update
);
  localparam int NIN = 9;

  function automatic logic pick_tick(input logic ext, input logic slow, input logic ext_edge,
                                     input logic fast_t, input logic slow_t);
    return ext ? ext_edge : (slow ? slow_t : fast_t);
  endfunction : pick_tick

  // Registers
  logic [31:0] ctrl;
  logic [31:0] sel0;
  logic [31:0] sel1;
  logic [4:0] oe;
  logic [CW-1:0] si_load;
  logic [CW-1:0] ci_load;
  logic [CW-1:0] ui_load;
  logic [7:0] nconv;
  logic [CW-1:0] c0_load;

  // APB decode
  wire acc = psel & penable;
  wire wr = acc & pready & pwrite;
  wire next_pready = acc & ~pready;
  wire wr_ctrl = wr & (paddr == `TSC_CTRL);
  logic [31:0] rd_data;
  logic unmapped;

  // Pin conditioning
  wire [3:0] sels [NIN];
  wire [NIN-1:0] lvl;
  wire [NIN-1:0] act;
  genvar gi;
  for (gi = 0; gi < NIN; gi++) begin : g_in
    if (gi < 8) begin : g_lo
      assign sels[gi] = sel0[4*gi +: 4];
    end else begin : g_hi
      assign sels[gi] = sel1[3:0];
    end
    tsc_pin_cond #(.NPIN(NPIN)) u_cond (
      .pclk(pclk),
      .presetn(presetn),
      .pins(programmable_function_pin_in),
      .sel(sels[gi]),
      .pol(sel1[`TSC_POL_LSB + gi]),
      .lvl(lvl[gi]),
      .act_edge(act[gi])
    );
  end

  // Internal timebases
  logic [8:0] tb_slow_cnt;
  logic tb_fast_cnt;
  wire tb_fast = (tb_fast_cnt == 1'(`TSC_TB_FAST_CYC - 1));
  wire tb_slow = (tb_slow_cnt == 9'(`TSC_TB_SLOW_CYC - 1));

  // Scan side
  tsc_scan_t scan_state;
  tsc_scan_t next_scan_state;
  logic [CW-1:0] si_cnt;
  logic [CW-1:0] ci_cnt;
  logic [7:0] conv_left;
  logic gate_off;
  wire seq = ctrl[`TSC_B_SEQ];
  wire si_tick = pick_tick(ctrl[`TSC_B_SI_EXT], ctrl[`TSC_B_SI_SLOW], act[TSC_IN_SICLK],
                           tb_fast, tb_slow);
  wire si_expire = seq & si_tick & (si_cnt == '0);
  wire scan_req = ctrl[`TSC_B_SCAN_EXT] ? act[TSC_IN_SCAN] : si_expire;
  wire gate_blocked = ctrl[`TSC_B_AI_SWGATE] |
                      (ctrl[`TSC_B_GATE_EDGE] ? gate_off : lvl[TSC_IN_GATE]);
  // Gate is only consulted when a scan would start, so a running scan is never cut
  wire scan_go = (scan_state == TSC_IDLE) & seq & scan_req & ~gate_blocked;
  wire scanning = scan_state == TSC_SCAN;
  wire conv_raw = ctrl[`TSC_B_CONV_EXT] ? act[TSC_IN_CONV] : (ci_cnt == '0);
  // External pulses arriving outside a scan are simply dropped; each one inside fires
  wire conv_fire = scanning & seq & conv_raw;
  wire scan_done = conv_fire & (conv_left == '0);

  always_comb begin
    case (scan_state)
      TSC_IDLE: next_scan_state = scan_go ? TSC_SCAN : TSC_IDLE;
      TSC_SCAN: next_scan_state = (scan_done | ~seq) ? TSC_IDLE : TSC_SCAN;
      default: next_scan_state = TSC_IDLE;
    endcase
  end

  // Update side
  logic ui_run;
  logic [CW-1:0] ui_cnt;
  logic [2:0] wf_cnt;
  logic [3:0] upd_cnt;
  wire wf_evt = act[TSC_IN_WF];
  wire ui_stop = (wr_ctrl & pwdata[`TSC_B_UI_STOP]) | buffer_expired;
  wire ui_tick = pick_tick(ctrl[`TSC_B_UI_EXT], ctrl[`TSC_B_UI_SLOW], act[TSC_IN_UICLK],
                           tb_fast, tb_slow);
  wire ui_expire = ui_run & ui_tick & (ui_cnt == '0);
  wire upd_raw = ctrl[`TSC_B_UPD_EXT] ? (act[TSC_IN_UPD] & ctrl[`TSC_B_POSTED]) : ui_expire;
  wire upd_fire = upd_raw & ~ctrl[`TSC_B_AO_SWGATE];
  wire [2:0] next_wf_cnt = wf_evt ? 3'(`TSC_WF_CYC) : (wf_cnt != '0 ? wf_cnt - 3'd1 : 3'd0);
  wire [3:0] next_upd_cnt = upd_fire ? 4'(`TSC_UPD_CYC) :
                            (upd_cnt != '0 ? upd_cnt - 4'd1 : 4'd0);

  // Counter 0
  logic [CW-1:0] c0_cnt;
  logic [CW-1:0] c0_latch;
  logic gate_run;
  logic c0_tog;
  logic dir_meta;
  logic dir_sync;
  wire c0_int_tick = ctrl[`TSC_B_C0_SLOW] ? tb_slow : tb_fast;
  wire c0_tick = pick_tick(ctrl[`TSC_B_C0_EXT], ctrl[`TSC_B_C0_SLOW], act[TSC_IN_C0CLK],
                           tb_fast, tb_slow);
  wire c0_run = ctrl[`TSC_B_C0_EN] & (~ctrl[`TSC_B_C0_GATECTL] | gate_run);
  wire c0_up = ctrl[`TSC_B_DIR_PIN] ? dir_sync : ctrl[`TSC_B_DIR_SW];
  wire c0_end = c0_run & c0_tick & (c0_up ? (c0_cnt == c0_load) : (c0_cnt == '0));
  wire next_c0_tog = c0_tog ^ c0_end;
  wire next_c0_out = ctrl[`TSC_B_C0_POL] ^ (ctrl[`TSC_B_C0_TOGGLE] ? next_c0_tog : c0_end);
  wire c0_clk_used = ctrl[`TSC_B_C0_EXT] ? lvl[TSC_IN_C0CLK] : c0_int_tick;

  // Pin drivers; scan gate and interval clocks never have a driver
  logic [NPIN-1:0] next_pin_out;
  logic [NPIN-1:0] next_pin_oe;
  always_comb begin
    next_pin_out = '0;
    next_pin_oe = '0;
    next_pin_out[`TSC_PIN_WF] = next_wf_cnt != '0;
    next_pin_out[`TSC_PIN_UPD] = next_upd_cnt == '0;
    next_pin_out[`TSC_PIN_C0CLK] = c0_clk_used;
    next_pin_out[`TSC_PIN_C0GATE] = lvl[TSC_IN_C0GATE];
    next_pin_oe[`TSC_PIN_UPD] = oe[0];
    next_pin_oe[`TSC_PIN_WF] = oe[1];
    next_pin_oe[`TSC_PIN_C0CLK] = oe[2];
    next_pin_oe[`TSC_PIN_C0GATE] = oe[3];
  end

  // Register read
  always_comb begin
    unmapped = 1'b0;
    case (paddr)
      `TSC_CTRL: rd_data = ctrl;
      `TSC_SEL0: rd_data = sel0;
      `TSC_SEL1: rd_data = sel1;
      `TSC_OE: rd_data = {27'h0, oe};
      `TSC_SI_LOAD: rd_data = 32'(si_load);
      `TSC_CI_LOAD: rd_data = 32'(ci_load);
      `TSC_UI_LOAD: rd_data = 32'(ui_load);
      `TSC_NCONV: rd_data = {24'h0, nconv};
      `TSC_C0_LOAD: rd_data = 32'(c0_load);
      `TSC_STATUS: rd_data = {27'h0, c0_up, c0_run, ui_run, gate_blocked, scanning};
      `TSC_C0_COUNT: rd_data = 32'(c0_cnt);
      `TSC_C0_LATCH: rd_data = 32'(c0_latch);
      default: begin
        rd_data = 32'h0;
        unmapped = 1'b1;
      end
    endcase
  end

  // APB answer: one wait state so the read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pready & unmapped;
      prdata <= next_pready & ~pwrite ? rd_data : 32'h0;
    end
  end

  // Register write; the stop bit is a command and does not stay set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 32'h0;
      sel0 <= 32'h0;
      sel1 <= 32'h0;
      oe <= 5'h0;
      si_load <= '0;
      ci_load <= '0;
      ui_load <= '0;
      nconv <= 8'h0;
      c0_load <= '0;
    end else if (wr) begin
      case (paddr)
        `TSC_CTRL: ctrl <= pwdata & ~(32'h1 << `TSC_B_UI_STOP);
        `TSC_SEL0: sel0 <= pwdata;
        `TSC_SEL1: sel1 <= pwdata;
        `TSC_OE: oe <= pwdata[4:0];
        `TSC_SI_LOAD: si_load <= pwdata[CW-1:0];
        `TSC_CI_LOAD: ci_load <= pwdata[CW-1:0];
        `TSC_UI_LOAD: ui_load <= pwdata[CW-1:0];
        `TSC_NCONV: nconv <= pwdata[7:0];
        `TSC_C0_LOAD: c0_load <= pwdata[CW-1:0];
        default: ;
      endcase
    end
  end

  // Timebases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_fast_cnt <= 1'b0;
      tb_slow_cnt <= 9'h0;
    end else begin
      tb_fast_cnt <= tb_fast ? 1'b0 : tb_fast_cnt + 1'b1;
      tb_slow_cnt <= tb_slow ? 9'h0 : tb_slow_cnt + 9'h1;
    end
  end

  // Scan interval, gate toggle and scan sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_state <= TSC_IDLE;
      si_cnt <= '0;
      gate_off <= 1'b0;
    end else begin
      scan_state <= next_scan_state;
      if (!seq) begin
        si_cnt <= si_load;
      end else if (si_tick) begin
        si_cnt <= (si_cnt == '0) ? si_load : si_cnt - 1'b1;
      end
      if (!ctrl[`TSC_B_GATE_EDGE]) begin
        gate_off <= 1'b0;
      end else if (act[TSC_IN_GATE]) begin
        gate_off <= ~gate_off;
      end
    end
  end

  // Conversion spacing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ci_cnt <= '0;
      conv_left <= 8'h0;
      adc_convert <= 1'b0;
    end else begin
      adc_convert <= conv_fire;
      if (!scanning || scan_done) begin
        ci_cnt <= ci_load;
      end else begin
        ci_cnt <= (ci_cnt == '0) ? ci_load : ci_cnt - 1'b1;
      end
      if (scan_go) begin
        conv_left <= nconv - 8'h1;
      end else if (conv_fire && conv_left != '0) begin
        conv_left <= conv_left - 8'h1;
      end
    end
  end

  // Update interval and output pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ui_run <= 1'b0;
      ui_cnt <= '0;
      wf_cnt <= 3'h0;
      upd_cnt <= 4'h0;
      dac_update <= 1'b0;
    end else begin
      if (ui_stop) begin
        ui_run <= 1'b0;
      end else if (wf_evt && !ctrl[`TSC_B_UPD_EXT]) begin
        ui_run <= 1'b1;
      end
      if (!ui_run) begin
        ui_cnt <= ui_load;
      end else if (ui_tick) begin
        ui_cnt <= (ui_cnt == '0) ? ui_load : ui_cnt - 1'b1;
      end
      wf_cnt <= next_wf_cnt;
      upd_cnt <= next_upd_cnt;
      dac_update <= upd_fire;
    end
  end

  // Counter 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_meta <= 1'b0;
      dir_sync <= 1'b0;
      c0_cnt <= '0;
      c0_latch <= '0;
      gate_run <= 1'b0;
      c0_tog <= 1'b0;
    end else begin
      dir_meta <= digital_line_six;
      dir_sync <= dir_meta;
      if (!ctrl[`TSC_B_C0_EN]) begin
        gate_run <= 1'b0;
      end else if (act[TSC_IN_C0GATE]) begin
        gate_run <= ~gate_run;
      end
      if (act[TSC_IN_C0GATE]) begin
        c0_latch <= c0_cnt;
      end
      if (!ctrl[`TSC_B_C0_EN]) begin
        c0_cnt <= c0_up ? '0 : c0_load;
      end else if (c0_run && c0_tick) begin
        if (c0_up) begin
          c0_cnt <= c0_end ? '0 : c0_cnt + 1'b1;
        end else begin
          c0_cnt <= c0_end ? c0_load : c0_cnt - 1'b1;
        end
      end
      c0_tog <= ctrl[`TSC_B_C0_EN] ? next_c0_tog : 1'b0;
    end
  end

  // Pin outputs, all from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      programmable_function_pin_out <= '0;
      programmable_function_pin_oe <= '0;
      counter0_output <= 1'b0;
      counter0_output_oe <= 1'b0;
    end else begin
      programmable_function_pin_out <= next_pin_out;
      programmable_function_pin_oe <= next_pin_oe;
      counter0_output <= next_c0_out;
      counter0_output_oe <= oe[4];
    end
  end
endmodule : tsc_top

// [test/tsc_top_props.sv]
// Port checker for the timing signal controller.
// Assumes binding to tsc_top; CTRL is mirrored from APB writes.
`timescale 1ns/10ps
`include "tsc_cfg.svh"
module tsc_props #(
  parameter int NPIN = 10
) (
  // Clock, reset, APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TSC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and converters
  input wire logic [NPIN-1:0] programmable_function_pin_out,
  input wire logic [NPIN-1:0] programmable_function_pin_oe,
  input wire logic counter0_output,
  input wire logic counter0_output_oe,
  input wire logic adc_convert,
  input wire logic dac_update
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] ctrl;
  logic [4:0] low_cnt;
  logic armed;
  wire wr = psel & penable & pready & pwrite;
  wire wr_oe = wr & (paddr == `TSC_OE);
  wire upd = programmable_function_pin_out[`TSC_PIN_UPD];
  wire wf = programmable_function_pin_out[`TSC_PIN_WF];
  wire seq = ctrl[`TSC_B_SEQ];
  wire ao_gate = ctrl[`TSC_B_AO_SWGATE];
  // Low time is only counted once the pin has been seen idle high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
      low_cnt <= '0;
      armed <= 1'b0;
    end else begin
      if (wr && paddr == `TSC_CTRL) ctrl <= pwdata;
      armed <= armed | upd;
      if (upd) low_cnt <= '0;
      else if (armed && low_cnt != 5'h1f) low_cnt <= low_cnt + 5'd1;
    end
  end
  property p_no_drive;
    programmable_function_pin_oe[4:0] == 5'h00 && !programmable_function_pin_oe[7];
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("input-only pin driven");
  property p_oe_sw;
    ((programmable_function_pin_oe & ~$past(programmable_function_pin_oe)) != '0)
      || $rose(counter0_output_oe) |-> $past(wr_oe, 2);
  endproperty
  a_oe_sw: assert property (p_oe_sw) else $error("output enabled without write");
  property p_wf_width;
    $rose(wf) |=> wf ##1 !wf;
  endproperty
  a_wf_width: assert property (p_wf_width) else $error("trigger pulse not 50 ns");
  property p_upd_width;
    $rose(upd) && armed |-> low_cnt == 5'd12;
  endproperty
  a_upd_width: assert property (p_upd_width) else $error("update pulse not 300 ns");
  property p_upd_gate;
    ao_gate && $past(ao_gate, 2) |-> !dac_update && !$fell(upd);
  endproperty
  a_upd_gate: assert property (p_upd_gate) else $error("update while gated");
  property p_adc_seq;
    !seq && !$past(seq) && !$past(seq, 2) |-> !adc_convert;
  endproperty
  a_adc_seq: assert property (p_adc_seq) else $error("conversion outside sequence");
  property p_c0_pulse;
    !ctrl[`TSC_B_C0_TOGGLE] && $stable(ctrl) && counter0_output != ctrl[`TSC_B_C0_POL]
      |=> counter0_output == ctrl[`TSC_B_C0_POL];
  endproperty
  a_c0_pulse: assert property (p_c0_pulse) else $error("count pulse too long");
  property p_apb_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("no ready after one wait");
  property p_err_ready;
    pslverr |-> pready && psel;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
endmodule : tsc_props

bind tsc_top tsc_props #(.NPIN(NPIN)) props_u (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .pslverr(pslverr),
  .programmable_function_pin_out(programmable_function_pin_out),
  .programmable_function_pin_oe(programmable_function_pin_oe),
  .counter0_output(counter0_output),
  .counter0_output_oe(counter0_output_oe),
  .adc_convert(adc_convert),
  .dac_update(dac_update)
);

// [test/tsc_instr.sv]
// Model of the instruments on the function pins: drives and senses them.
// Assumes the bench resolves each pin from the block's enables.
`timescale 1ns/10ps
module tsc_instr #(
  parameter int NPIN = 10
) (
  // Timing reference
  input wire logic pclk,
  // Resolved pins
  input wire logic [NPIN-1:0] pin_level,
  input wire logic [NPIN-1:0] pin_oe,
  // Instrument drive
  output logic [NPIN-1:0] drive
);
  int wf_cnt = 0;
  realtime upd_fall = 0;
  realtime upd_low = 0;
  initial drive = '0;
  // Four cycles each way keeps pulses well under 20 MHz and wider than 23 ns
  task automatic pulse(input int idx);
    @(posedge pclk) drive[idx] <= 1'b1;
    repeat (4) @(posedge pclk);
    drive[idx] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pulse
  task automatic set_pin(input int idx, input logic v);
    @(posedge pclk) drive[idx] <= v;
  endtask : set_pin
  always @(posedge pin_level[6]) if (pin_oe[6]) wf_cnt++;
  always @(negedge pin_level[5]) upd_fall = $realtime;
  always @(posedge pin_level[5]) if (pin_oe[5]) upd_low = $realtime - upd_fall;
endmodule : tsc_instr

// [test/test_timing_signal_controller.sv]
// Self-checking bench: APB tasks, instrument model on pins, event counts.
// Assumes tsc_top defaults and the map in tsc_cfg.svh.
`timescale 1ns/10ps
`include "tsc_cfg.svh"
module test_timing_signal_controller;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] pin_out;
  logic [9:0] pin_oe;
  logic [9:0] drive;
  logic dir_pin = 1'b0;
  logic buffer_expired = 1'b0;
  logic c0_oe;
  logic c0_out;
  logic adc_convert;
  logic dac_update;
  wire [9:0] pin_lvl = (pin_out & pin_oe) | (drive & ~pin_oe);
  int n_errors = 0;
  int n_compared = 0;
  int n_adc = 0;
  int n_dac = 0;
  int n_c0_out = 0;
  int base;
  logic [31:0] q;
  logic [31:0] c0;
  logic err;

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (adc_convert === 1'b1) n_adc <= n_adc + 1;
    if (dac_update === 1'b1) n_dac <= n_dac + 1;
    if (c0_out === 1'b1) n_c0_out <= n_c0_out + 1;
  end

  tsc_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .programmable_function_pin_in(pin_lvl), .programmable_function_pin_out(pin_out),
    .programmable_function_pin_oe(pin_oe), .digital_line_six(dir_pin),
    .counter0_output(c0_out), .counter0_output_oe(c0_oe),
    .buffer_expired(buffer_expired), .adc_convert(adc_convert), .dac_update(dac_update)
  );
  tsc_instr mdl_u (.pclk(pclk), .pin_level(pin_lvl), .pin_oe(pin_oe), .drive(drive));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    q = prdata;
    err = pslverr;
    if (t >= 50) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Two conversions per scan; the count over the window shows what was accepted
  task automatic run_scan(input logic [31:0] ctrl, input int exp);
    apb(1'b1, `TSC_CTRL, ctrl);
    base = n_adc;
    mdl_u.pulse(0);
    repeat (30) @(posedge pclk);
    chk(32'(n_adc - base), 32'(exp));
  endtask : run_scan
  task automatic upd_window(input int exp_any);
    repeat (50) @(posedge pclk);
    base = n_dac;
    repeat (200) @(posedge pclk);
    chk(32'(n_dac != base), 32'(exp_any));
  endtask : upd_window
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({pin_oe, c0_oe}, '0);
    apb(1'b0, 8'h30, 32'h0);
    chk({q[30:0], err}, 32'h1);
    apb(1'b1, `TSC_SEL0, 32'h40730210);
    apb(1'b1, `TSC_SEL1, 32'h9);
    apb(1'b1, `TSC_CI_LOAD, 32'd2);
    apb(1'b1, `TSC_NCONV, 32'd2);
    run_scan(32'h1001, 2);
    run_scan(32'h1000, 0);
    run_scan(32'h1003, 0);
    mdl_u.set_pin(2, 1'b1);
    run_scan(32'h1001, 0);
    mdl_u.set_pin(2, 1'b0);
    apb(1'b1, `TSC_CTRL, 32'h1801);
    mdl_u.pulse(2);
    run_scan(32'h1801, 0);
    mdl_u.pulse(2);
    run_scan(32'h1801, 2);
    apb(1'b1, `TSC_CI_LOAD, 32'd20);
    apb(1'b1, `TSC_CTRL, 32'h1001);
    base = n_adc;
    mdl_u.pulse(0);
    mdl_u.set_pin(2, 1'b1);
    repeat (80) @(posedge pclk);
    chk(32'(n_adc - base), 32'd2);
    mdl_u.set_pin(2, 1'b0);
    apb(1'b1, `TSC_CI_LOAD, 32'd2);
    apb(1'b1, `TSC_CTRL, 32'h1011);
    base = n_adc;
    mdl_u.pulse(1);
    mdl_u.pulse(0);
    repeat (3) mdl_u.pulse(1);
    chk(32'(n_adc - base), 32'd2);
    apb(1'b1, `TSC_OE, 32'h3);
    apb(1'b1, `TSC_UI_LOAD, 32'd19);
    apb(1'b1, `TSC_CTRL, 32'h0);
    mdl_u.pulse(3);
    upd_window(1);
    chk(32'(mdl_u.wf_cnt), 32'd1);
    chk(32'($rtoi(mdl_u.upd_low)), 32'd300);
    apb(1'b1, `TSC_CTRL, 32'h40);
    upd_window(0);
    apb(1'b1, `TSC_CTRL, 32'h0);
    mdl_u.pulse(3);
    buffer_expired <= 1'b1;
    upd_window(0);
    buffer_expired <= 1'b0;
    apb(1'b1, `TSC_CTRL, 32'h40);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `TSC_CTRL, (i == 0) ? 32'h20 : (i == 1) ? 32'h28 : 32'h2c);
      base = n_dac;
      mdl_u.pulse(7);
      repeat (20) @(posedge pclk);
      chk(32'(n_dac - base), 32'(i == 1));
    end
    apb(1'b1, `TSC_OE, 32'h13);
    apb(1'b1, `TSC_C0_LOAD, 32'd100);
    // Direction is set while disabled so the count presets to zero, not to the load value
    apb(1'b1, `TSC_CTRL, 32'h20100);
    apb(1'b1, `TSC_CTRL, 32'ha0100);
    apb(1'b0, `TSC_C0_COUNT, 32'h0);
    c0 = q;
    repeat (3) mdl_u.pulse(4);
    apb(1'b0, `TSC_C0_COUNT, 32'h0);
    chk(q, c0 + 32'd3);
    apb(1'b1, `TSC_CTRL, 32'ha0180);
    repeat (2) mdl_u.pulse(4);
    apb(1'b0, `TSC_C0_COUNT, 32'h0);
    chk(q, c0 + 32'd1);
    dir_pin <= 1'b1;
    mdl_u.pulse(4);
    mdl_u.pulse(9);
    apb(1'b0, `TSC_C0_LATCH, 32'h0);
    chk(q, c0 + 32'd2);
    chk({31'h0, c0_oe}, 32'h1);
    dir_pin <= 1'b0;
    repeat (4) mdl_u.pulse(4);
    chk(32'(n_c0_out), 32'd1);
    end_sim();
  end
endmodule : test_timing_signal_controller
